// File: sfmwr_pkg.sv
`default_nettype none
package sfmwr_pkg;
   // Opcodes
   localparam logic [7:0] OP_QPI_ON   = 8'h38;
   localparam logic [7:0] OP_QPI_OFF  = 8'hFF;
   localparam logic [7:0] OP_WORD_RD  = 8'hE7;
   localparam logic [7:0] OP_QUAD_RD  = 8'hEB;
   localparam logic [7:0] OP_SET_WRAP = 8'h77;
   localparam logic [7:0] OP_WRAP_RD  = 8'h0C;
   localparam logic [7:0] OP_FAST_RD  = 8'h0B;
   localparam logic [7:0] OP_SET_PARM = 8'hC0;
   localparam logic [7:0] OP_RST_ARM  = 8'h66;
   localparam logic [7:0] OP_RST      = 8'h99;
   localparam logic [7:0] OP_WR_EN    = 8'h06;
   localparam logic [7:0] OP_WR_DIS   = 8'h04;
   localparam logic [7:0] OP_SUSPEND  = 8'h75;
   localparam logic [7:0] OP_RESUME   = 8'h7A;

   // Continuous read keep code in the upper mode nibble
   localparam logic [3:0] CRM_KEEP = 4'hA;

   // Serial clocks per phase
   localparam logic [3:0] SPI_OPC_CLKS  = 4'h8;
   localparam logic [3:0] QPI_OPC_CLKS  = 4'h2;
   localparam logic [3:0] ADDR_CLKS     = 4'h6;
   localparam logic [3:0] MODE_CLKS     = 4'h2;
   localparam logic [3:0] PARM_CLKS     = 4'h2;
   localparam logic [3:0] WORD_RD_DUMMY = 4'h2;
   localparam logic [3:0] QUAD_RD_DUMMY = 4'h4;
   localparam logic [3:0] DUMMY_4       = 4'h4;
   localparam logic [3:0] DUMMY_6       = 4'h6;
   localparam logic [3:0] DUMMY_8       = 4'h8;

   // Field positions
   localparam int WRAP_FIELD_LO = 4;
   localparam int WRAP_DIS_POS  = 0;
   localparam int PARM_DUMMY_LO = 4;

   // Values after reset
   localparam logic [2:0] WRAP_RESET = 3'h1;
   localparam logic [7:0] PARM_RESET = 8'h00;
   localparam logic [5:0] SYNC_RESET = 6'h01;

   // Software reset recovery time
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_RST_NS      = 30000;
   localparam int RST_CYCLES_I  = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] RST_CYCLES = 9'(RST_CYCLES_I);

   typedef enum logic [7:0] {
      ST_IDLE   = 8'h01,
      ST_OPC    = 8'h02,
      ST_ADDR   = 8'h04,
      ST_MODE   = 8'h08,
      ST_DUMMY  = 8'h10,
      ST_DATA   = 8'h20,
      ST_PARM   = 8'h40,
      ST_IGNORE = 8'h80
   } sfmwr_state_t;
endpackage : sfmwr_pkg
`default_nettype wire

// File: sfmwr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sfmwr_sync (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       reset_n,
   // Pin levels in and synchronised out
   input  wire logic [5:0] pins_in,
   output logic      [5:0] pins_sync
);
   logic [5:0] meta_reg;
   logic [5:0] sync_reg;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= sfmwr_pkg::SYNC_RESET;
         sync_reg <= sfmwr_pkg::SYNC_RESET;
      end else begin
         meta_reg <= pins_in;
         sync_reg <= meta_reg;
      end
   end

   assign pins_sync = sync_reg;
endmodule : sfmwr_sync
`default_nettype wire

// File: sfmwr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sfmwr_ctrl (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // Serial flash pins
   input  wire logic        cs_n_pin,
   input  wire logic        sck_pin,
   input  wire logic [3:0]  io_in,
   output logic      [3:0]  io_out,
   output logic      [3:0]  io_oe,
   // Array and status side
   input  wire logic        quad_enable_bit,
   input  wire logic        array_busy,
   input  wire logic [7:0]  rd_data,
   output logic      [23:0] rd_addr,
   output logic             abort_op,
   output logic             busy_flag,
   // Volatile state
   output logic             write_enable_latch,
   output logic             suspend_flag,
   output logic             four_wire_command_mode,
   output logic      [2:0]  wrap_config_bits,
   output logic             continuous_read_mode,
   output logic      [7:0]  read_params
);
   // Wrapped address step inside an aligned 8/16/32/64 byte section
   function automatic logic [23:0] addr_step(input logic [23:0] a, input logic wrap_on, input logic [1:0] len);
      logic [23:0] mask;
      logic [23:0] inc;
      mask = {18'h0, len == 2'h3, len[1], |len, 3'h7};
      inc  = a + 24'h1;
      return wrap_on ? ((a & ~mask) | (inc & mask)) : inc;
   endfunction : addr_step

   // Dummy clocks taken from the read parameter field
   function automatic logic [3:0] parm_dummy(input logic [1:0] sel);
      unique case (sel)
         2'h0:    return sfmwr_pkg::DUMMY_4;
         2'h1:    return sfmwr_pkg::DUMMY_6;
         default: return sfmwr_pkg::DUMMY_8;
      endcase
   endfunction : parm_dummy

   logic [5:0]               pins_s;
   logic                     cs_s;
   logic                     sck_s;
   logic [3:0]               io_s;
   logic                     sck_d_reg;
   logic                     cs_d_reg;
   sfmwr_pkg::sfmwr_state_t  state_reg;
   sfmwr_pkg::sfmwr_state_t  state_next;
   logic [3:0]               cnt_reg;
   logic [31:0]              sh_reg;
   logic [7:0]               op_reg;
   logic [23:0]              addr_reg;
   logic                     nib_hi_reg;
   logic [3:0]               io_out_reg;
   logic [3:0]               io_oe_reg;
   logic                     qpi_reg;
   logic                     wel_reg;
   logic                     sus_reg;
   logic                     crm_reg;
   logic                     armed_reg;
   logic [2:0]               wrap_reg;
   logic [7:0]               parm_reg;
   logic [8:0]               rst_cnt_reg;
   logic                     abort_reg;
   logic                     busy_reg;

   sfmwr_sync u_sync (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .pins_in   ({io_in, sck_pin, cs_n_pin}),
      .pins_sync (pins_s)
   );

   assign cs_s  = pins_s[0];
   assign sck_s = pins_s[1];
   assign io_s  = pins_s[5:2];

   // Edges of the host clock and chip select
   wire sck_rise = sck_s & ~sck_d_reg & ~cs_s;
   wire sck_fall = ~sck_s & sck_d_reg & ~cs_s;
   wire cs_fall  = ~cs_s & cs_d_reg;
   wire cs_rise  = cs_s & ~cs_d_reg;

   // Bit collection: one line for serial opcodes, four lines otherwise
   wire        wide     = (state_reg != sfmwr_pkg::ST_OPC) | qpi_reg;
   wire [31:0] sh_quad  = {sh_reg[27:0], io_s};
   wire [31:0] sh_one   = {sh_reg[30:0], io_s[0]};
   wire [31:0] sh_next  = wide ? sh_quad : sh_one;
   wire [7:0]  op_in    = sh_next[7:0];
   wire        rst_busy = rst_cnt_reg != 9'h0;

   wire is_word  = op_reg == sfmwr_pkg::OP_WORD_RD;
   wire is_quad  = op_reg == sfmwr_pkg::OP_QUAD_RD;
   wire is_wrapr = op_reg == sfmwr_pkg::OP_WRAP_RD;
   wire is_setw  = op_reg == sfmwr_pkg::OP_SET_WRAP;
   wire is_parm  = op_reg == sfmwr_pkg::OP_SET_PARM;

   wire [3:0] dummy_len = is_word ? sfmwr_pkg::WORD_RD_DUMMY :
                          is_quad ? sfmwr_pkg::QUAD_RD_DUMMY :
                          parm_dummy(parm_reg[sfmwr_pkg::PARM_DUMMY_LO +: 2]);

   wire [3:0] phase_len =
      (state_reg == sfmwr_pkg::ST_OPC)   ? (qpi_reg ? sfmwr_pkg::QPI_OPC_CLKS : sfmwr_pkg::SPI_OPC_CLKS) :
      (state_reg == sfmwr_pkg::ST_ADDR)  ? sfmwr_pkg::ADDR_CLKS :
      (state_reg == sfmwr_pkg::ST_MODE)  ? sfmwr_pkg::MODE_CLKS :
      (state_reg == sfmwr_pkg::ST_DUMMY) ? dummy_len :
      (state_reg == sfmwr_pkg::ST_PARM)  ? sfmwr_pkg::PARM_CLKS : 4'h0;

   // Data and ignored phases have no length, so they never end on a count
   wire has_len   = phase_len != 4'h0;
   wire cnt_last  = sck_rise & has_len & (cnt_reg == phase_len - 4'h1);
   wire opc_done  = cnt_last & (state_reg == sfmwr_pkg::ST_OPC);
   wire addr_done = cnt_last & (state_reg == sfmwr_pkg::ST_ADDR);
   wire mode_done = cnt_last & (state_reg == sfmwr_pkg::ST_MODE);
   wire parm_done = cnt_last & (state_reg == sfmwr_pkg::ST_PARM);

   // Opcode acceptance by mode and quad enable
   // serial only entry
   wire acc_qpi_on  = ~qpi_reg & quad_enable_bit & (op_in == sfmwr_pkg::OP_QPI_ON);
   wire acc_qpi_off = qpi_reg & (op_in == sfmwr_pkg::OP_QPI_OFF);
   wire acc_word    = ~qpi_reg & quad_enable_bit & (op_in == sfmwr_pkg::OP_WORD_RD);
   wire acc_quad    = ~qpi_reg & quad_enable_bit & (op_in == sfmwr_pkg::OP_QUAD_RD);
   wire acc_setw    = ~qpi_reg & quad_enable_bit & (op_in == sfmwr_pkg::OP_SET_WRAP);
   wire acc_qread   = qpi_reg & ((op_in == sfmwr_pkg::OP_WRAP_RD) | (op_in == sfmwr_pkg::OP_FAST_RD));
   wire acc_parm    = qpi_reg & (op_in == sfmwr_pkg::OP_SET_PARM);
   wire soft_rst    = opc_done & armed_reg & (op_in == sfmwr_pkg::OP_RST);
   wire to_addr     = acc_word | acc_quad | acc_setw | acc_qread;

   // Read address stepping and wrap selection
   // wrap bits govern word and quad reads
   wire wrap_on = ((is_word | is_quad) & ~wrap_reg[sfmwr_pkg::WRAP_DIS_POS]) | is_wrapr;
   wire [23:0] addr_inc = addr_step(addr_reg, wrap_on, wrap_reg[2:1]);
   wire        step_now = sck_fall & (state_reg == sfmwr_pkg::ST_DATA) & ~nib_hi_reg;
   wire [23:0] addr_next = addr_done ? sh_next[23:0] : (step_now ? addr_inc : addr_reg);

   // Frame sequencing
   always_comb begin
      state_next = state_reg;
      if (cs_s) begin
         state_next = sfmwr_pkg::ST_IDLE;
      end else if (cs_fall) begin
         state_next = rst_busy ? sfmwr_pkg::ST_IGNORE :
                      crm_reg  ? sfmwr_pkg::ST_ADDR : sfmwr_pkg::ST_OPC;
      end else if (cnt_last) begin
         unique case (state_reg)
            sfmwr_pkg::ST_OPC: begin
               state_next = to_addr  ? sfmwr_pkg::ST_ADDR :
                            acc_parm ? sfmwr_pkg::ST_PARM : sfmwr_pkg::ST_IGNORE;
            end
            sfmwr_pkg::ST_ADDR: begin
               state_next = (is_word | is_quad) ? sfmwr_pkg::ST_MODE :
                            is_setw ? sfmwr_pkg::ST_PARM : sfmwr_pkg::ST_DUMMY;
            end
            sfmwr_pkg::ST_MODE: begin
               state_next = sfmwr_pkg::ST_DUMMY;
            end
            sfmwr_pkg::ST_DUMMY: begin
               state_next = sfmwr_pkg::ST_DATA;
            end
            sfmwr_pkg::ST_PARM: begin
               state_next = sfmwr_pkg::ST_IGNORE;
            end
            // Data and ignored phases hold until chip select rises
            sfmwr_pkg::ST_DATA, sfmwr_pkg::ST_IGNORE: begin
               state_next = state_reg;
            end
            default: begin
               state_next = sfmwr_pkg::ST_IGNORE;
            end
         endcase
      end
   end

   // Next values of the volatile state
   // single mode flag
   wire qpi_next = soft_rst ? 1'b0 : (opc_done & acc_qpi_on) ? 1'b1 :
                   (opc_done & acc_qpi_off) ? 1'b0 : qpi_reg;
   wire wel_next = soft_rst ? 1'b0 :
                   (opc_done & (op_in == sfmwr_pkg::OP_WR_EN)) ? 1'b1 :
                   (opc_done & (op_in == sfmwr_pkg::OP_WR_DIS)) ? 1'b0 : wel_reg;
   wire sus_next = soft_rst ? 1'b0 :
                   (opc_done & array_busy & (op_in == sfmwr_pkg::OP_SUSPEND)) ? 1'b1 :
                   (opc_done & (op_in == sfmwr_pkg::OP_RESUME)) ? 1'b0 : sus_reg;
   wire crm_next = soft_rst ? 1'b0 :
                   mode_done ? (sh_next[7:4] == sfmwr_pkg::CRM_KEEP) : crm_reg;
   wire crm_start  = cs_fall & crm_reg;
   wire armed_next = opc_done ? (op_in == sfmwr_pkg::OP_RST_ARM) :
                     crm_start ? 1'b0 : armed_reg;
   wire [2:0] wrap_next = soft_rst ? sfmwr_pkg::WRAP_RESET :
                          (parm_done & is_setw) ? sh_next[sfmwr_pkg::WRAP_FIELD_LO +: 3] : wrap_reg;
   wire [7:0] parm_next = soft_rst ? sfmwr_pkg::PARM_RESET :
                          (parm_done & is_parm) ? sh_next[7:0] : parm_reg;
   wire [8:0] rst_cnt_next = soft_rst ? sfmwr_pkg::RST_CYCLES :
                             rst_busy ? rst_cnt_reg - 9'h1 : rst_cnt_reg;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sck_d_reg <= 1'b0;
         cs_d_reg  <= 1'b1;
         state_reg <= sfmwr_pkg::ST_IDLE;
      end else begin
         sck_d_reg <= sck_s;
         cs_d_reg  <= cs_s;
         state_reg <= state_next;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= 4'h0;
         sh_reg  <= 32'h0;
      end else if (cs_fall | cnt_last) begin
         cnt_reg <= 4'h0;
         sh_reg  <= cs_fall ? 32'h0 : sh_next;
      end else if (sck_rise) begin
         cnt_reg <= cnt_reg + 4'h1;
         sh_reg  <= sh_next;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         op_reg   <= 8'h00;
         addr_reg <= 24'h0;
      end else begin
         op_reg   <= opc_done ? op_in : op_reg;
         addr_reg <= addr_next;
      end
   end

   // Nibble output on falling host clock, high nibble first
   // drive only from first data fall
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         nib_hi_reg <= 1'b1;
         io_out_reg <= 4'h0;
         io_oe_reg  <= 4'h0;
      end else if (cs_s | cs_fall) begin
         nib_hi_reg <= 1'b1;
         io_oe_reg  <= 4'h0;
      end else if (sck_fall & (state_reg == sfmwr_pkg::ST_DATA)) begin
         nib_hi_reg <= ~nib_hi_reg;
         io_out_reg <= nib_hi_reg ? rd_data[7:4] : rd_data[3:0];
         io_oe_reg  <= 4'hF;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         qpi_reg   <= 1'b0;
         wel_reg   <= 1'b0;
         sus_reg   <= 1'b0;
         crm_reg   <= 1'b0;
         armed_reg <= 1'b0;
         wrap_reg  <= sfmwr_pkg::WRAP_RESET;
         parm_reg  <= sfmwr_pkg::PARM_RESET;
      end else begin
         qpi_reg   <= qpi_next;
         wel_reg   <= wel_next;
         sus_reg   <= sus_next;
         crm_reg   <= crm_next;
         armed_reg <= armed_next;
         wrap_reg  <= wrap_next;
         parm_reg  <= parm_next;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_cnt_reg <= 9'h0;
         abort_reg   <= 1'b0;
         busy_reg    <= 1'b0;
      end else begin
         rst_cnt_reg <= rst_cnt_next;
         abort_reg   <= soft_rst;
         busy_reg    <= array_busy | rst_busy;
      end
   end

   assign io_out                 = io_out_reg;
   assign io_oe                  = io_oe_reg;
   assign rd_addr                = addr_reg;
   assign abort_op               = abort_reg;
   assign busy_flag              = busy_reg;
   assign write_enable_latch     = wel_reg;
   assign suspend_flag           = sus_reg;
   assign four_wire_command_mode = qpi_reg;
   assign wrap_config_bits       = wrap_reg;
   assign continuous_read_mode   = crm_reg;
   assign read_params            = parm_reg;
endmodule : sfmwr_ctrl
`default_nettype wire

// File: sfmwr_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sfmwr_ctrl_sva (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        reset_n,
   // Pins
   input wire logic        cs_n_pin,
   input wire logic [3:0]  io_oe,
   // Array side
   input wire logic        quad_enable_bit,
   input wire logic        array_busy,
   input wire logic [23:0] rd_addr,
   input wire logic        abort_op,
   input wire logic        busy_flag,
   // Volatile state
   input wire logic        write_enable_latch,
   input wire logic        suspend_flag,
   input wire logic        four_wire_command_mode,
   input wire logic [2:0]  wrap_config_bits,
   input wire logic        continuous_read_mode,
   input wire logic [7:0]  read_params
);
   logic [8:0]  rcnt;
   logic [23:0] wmask;
   logic        in_rec;
   // Address bits above the wrap section
   assign wmask  = 24'hFFFFF8 << wrap_config_bits[2:1];
   assign in_rec = rcnt > 9'h003 && rcnt < 9'h127;
   // Cycles since an accepted soft reset
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) rcnt <= 9'h000;
      else if (abort_op) rcnt <= 9'h001;
      else if (rcnt != 9'h000 && rcnt < 9'h12C) rcnt <= rcnt + 9'h001;
      else rcnt <= 9'h000;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence s_clean;
      !four_wire_command_mode && !write_enable_latch && !suspend_flag && !continuous_read_mode
         && wrap_config_bits == 3'h1 && read_params == 8'h00;
   endsequence
   sequence s_desel;
      cs_n_pin [*6];
   endsequence
   sequence s_rec_start;
      ##[1:3] busy_flag ##1 busy_flag;
   endsequence
   property p_reset_vals; $rose(reset_n) |-> s_clean; endproperty
   property p_mode_qe; $rose(four_wire_command_mode) |-> quad_enable_bit && !cs_n_pin; endproperty
   property p_mode_keep;
      $changed(four_wire_command_mode) && !abort_op |->
         $stable(write_enable_latch) && $stable(suspend_flag) && $stable(wrap_config_bits);
   endproperty
   property p_abort_clear; abort_op |-> s_clean; endproperty
   property p_rst_busy; abort_op |-> s_rec_start; endproperty
   property p_rst_hold; in_rec |-> busy_flag && !abort_op && $stable(four_wire_command_mode); endproperty
   property p_busy; array_busy |=> busy_flag; endproperty
   property p_oe_whole; io_oe == 4'h0 || io_oe == 4'hF; endproperty
   property p_oe_off; s_desel |-> io_oe == 4'h0; endproperty
   property p_wrap_addr;
      !cs_n_pin && !wrap_config_bits[0] && io_oe == 4'hF && $past(io_oe) == 4'hF |->
         ((rd_addr ^ $past(rd_addr)) & wmask) == 24'h000000;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("state not clean after reset");
   a_mode_qe: assert property (p_mode_qe)
      else $error("mode entered without quad enable");
   a_mode_keep: assert property (p_mode_keep)
      else $error("mode switch disturbed latch, suspend or wrap");
   a_abort_clear: assert property (p_abort_clear)
      else $error("soft reset left volatile state");
   a_rst_busy: assert property (p_rst_busy)
      else $error("busy not raised after soft reset");
   a_rst_hold: assert property (p_rst_hold)
      else $error("activity during reset recovery");
   a_busy: assert property (p_busy)
      else $error("busy flag low while array busy");
   a_oe_whole: assert property (p_oe_whole)
      else $error("partial output enable");
   a_oe_off: assert property (p_oe_off)
      else $error("output enabled while deselected");
   a_wrap_addr: assert property (p_wrap_addr)
      else $error("read address left wrap section");
endmodule : sfmwr_ctrl_sva
bind sfmwr_ctrl sfmwr_ctrl_sva u_sva (.mclk, .reset_n, .cs_n_pin, .io_oe, .quad_enable_bit, .array_busy,
   .rd_addr, .abort_op, .busy_flag, .write_enable_latch, .suspend_flag, .four_wire_command_mode,
   .wrap_config_bits, .continuous_read_mode, .read_params);
`default_nettype wire

// File: sfmwr_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfmwr_host (
   // Clock
   input  wire logic       mclk,
   // Pins toward the device
   output var logic        cs_n_pin,
   output var logic        sck_pin,
   output var logic  [3:0] io_in,
   // Pins from the device
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe
);
   logic [3:0] got[$];
   logic [3:0] oe_any;
   initial begin
      cs_n_pin = 1'b1;
      sck_pin  = 1'b0;
      io_in    = 4'h0;
      oe_any   = 4'h0;
   end
   task automatic half();
      repeat (4) @(posedge mclk);
   endtask : half
   task automatic tick(input logic [3:0] v);
      io_in <= v;
      half();
      sck_pin <= 1'b1;
      half();
      sck_pin <= 1'b0;
   endtask : tick
   task automatic sel();
      cs_n_pin <= 1'b0;
   endtask : sel
   // Bits or nibbles, most significant first
   task automatic shift(input logic [31:0] v, input int n, input bit one);
      for (int i = n - 1; i >= 0; i--) begin
         if (one) tick({4{v[i]}});
         else tick(v[4*i+:4]);
      end
   endtask : shift
   // lines released before the first data fall
   task automatic rd(input int skip, input int n);
      got.delete();
      oe_any = 4'h0;
      io_in <= ~io_in;
      for (int i = 0; i < skip + n; i++) begin
         half();
         sck_pin <= 1'b1;
         half();
         if (i >= skip) got.push_back(io_out);
         oe_any = oe_any | io_oe;
         sck_pin <= 1'b0;
      end
   endtask : rd
   // Released lines show the inverse of the last value
   task automatic fin();
      half();
      cs_n_pin <= 1'b1;
      io_in <= ~io_in;
      repeat (8) @(posedge mclk);
   endtask : fin
endmodule : sfmwr_host
`default_nettype wire

// File: sfmwr_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module sfmwr_ctrl_tb;
   logic        mclk, reset_n, quad_enable_bit, array_busy, cs_n_pin, sck_pin, abort_op, busy_flag;
   logic        write_enable_latch, suspend_flag, four_wire_command_mode, continuous_read_mode;
   logic [3:0]  io_in, io_out, io_oe;
   logic [7:0]  rd_data, read_params, w;
   logic [2:0]  wrap_config_bits;
   logic [23:0] rd_addr, a;
   logic [7:0]  mem [256];
   int          miscompares, n_compared, seed;
   sfmwr_ctrl u_dut (.mclk, .reset_n, .cs_n_pin, .sck_pin, .io_in, .io_out, .io_oe, .quad_enable_bit,
      .array_busy, .rd_data, .rd_addr, .abort_op, .busy_flag, .write_enable_latch, .suspend_flag,
      .four_wire_command_mode, .wrap_config_bits, .continuous_read_mode, .read_params);
   sfmwr_host u_host (.mclk, .cs_n_pin, .sck_pin, .io_in, .io_out, .io_oe);
   assign rd_data = mem[rd_addr[7:0]] ^ rd_addr[15:8];
   always #50 mclk = ~mclk;
   task automatic end_sim();
      if (miscompares == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   function automatic logic [7:0] eb(input logic [23:0] s, input int k, input int len);
      logic [23:0] x;
      x = (len == 0) ? s + 24'(k) : (s & ~24'(len - 1)) | ((s + 24'(k)) & 24'(len - 1));
      return mem[x[7:0]] ^ x[15:8];
   endfunction : eb
   task automatic chk_rd(input logic [23:0] s, input int len, input int n);
      for (int k = 0; k < n; k++) `CHK("byte", eb(s, k, len), {u_host.got[2*k], u_host.got[2*k+1]})
   endtask : chk_rd
   task automatic cmd(input logic [7:0] o, input logic [31:0] v, input int n);
      u_host.sel();
      if (four_wire_command_mode) u_host.shift({24'h0, o}, 2, 1'b0);
      else u_host.shift({24'h0, o}, 8, 1'b1);
      u_host.shift(v, n, 1'b0);
      u_host.fin();
   endtask : cmd
   // even address, mode byte, two dummies
   task automatic wrd(input logic [23:0] s, input logic [7:0] m, input bit noop, input int n);
      u_host.sel();
      if (!noop) u_host.shift(32'hE7, 8, 1'b1);
      u_host.shift({8'h0, s}, 6, 1'b0);
      u_host.shift({24'h0, m}, 2, 1'b0);
      u_host.rd(2, 2 * n);
      u_host.fin();
   endtask : wrd
   task automatic wait_idle();
      int i;
      for (i = 0; i < 1000 && busy_flag !== 1'b0; i++) @(posedge mclk);
      if (i == 1000) begin
         miscompares++;
         end_sim();
      end
   endtask : wait_idle
   initial begin
      mclk = 1'b0;
      reset_n = 1'b0;
      quad_enable_bit = 1'b0;
      array_busy = 1'b0;
      seed = 41;
      foreach (mem[i]) mem[i] = 8'($random(seed));
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (6) @(posedge mclk);
      cmd(8'h38, 0, 0);
      `CHK("mode", 1'b0, four_wire_command_mode)
      cmd(8'h77, 0, 8);
      `CHK("wrap", 3'h1, wrap_config_bits)
      wrd(24'h000010, 8'h00, 0, 2);
      `CHK("oe", 4'h0, u_host.oe_any)
      quad_enable_bit <= 1'b1;
      cmd(8'h06, 0, 0);
      array_busy <= 1'b1;
      cmd(8'h75, 0, 0);
      array_busy <= 1'b0;
      for (int l = 0; l < 4; l++) begin
         w = (8'($random(seed)) & 8'h8F) | 8'(l << 5);
         cmd(8'h77, {24'($random(seed)), w}, 8);
         `CHK("wrap", {2'(l), 1'b0}, wrap_config_bits)
         a = (24'($random(seed)) & ~24'((8 << l) - 1)) | 24'((8 << l) - 4);
         wrd(a, 8'h00, 0, 8);
         chk_rd(a, 8 << l, 8);
         u_host.sel();
         u_host.shift(32'hEB, 8, 1'b1);
         u_host.shift({8'h0, a}, 6, 1'b0);
         u_host.shift(32'h0, 2, 1'b0);
         u_host.rd(4, 16);
         u_host.fin();
         chk_rd(a, 8 << l, 8);
      end
      wrd(a, 8'hA5, 0, 3);
      `CHK("crm", 1'b1, continuous_read_mode)
      wrd(a, 8'h00, 1, 3);
      chk_rd(a, 64, 3);
      wrd(a, 8'h00, 0, 3);
      chk_rd(a, 64, 3);
      cmd(8'h77, 32'h70, 8);
      wrd(a, 8'h00, 0, 6);
      chk_rd(a, 0, 6);
      cmd(8'h38, 0, 0);
      `CHK("keep", 6'h3F, {four_wire_command_mode, write_enable_latch, suspend_flag, wrap_config_bits})
      for (int p = 0; p < 4; p++) begin
         cmd(8'hC0, 32'(p << 4), 2);
         `CHK("parm", 8'(p << 4), read_params)
         u_host.sel();
         u_host.shift((p == 3) ? 32'h0B : 32'h0C, 2, 1'b0);
         u_host.shift({8'h0, a}, 6, 1'b0);
         u_host.rd((p == 3) ? 8 : 4 + 2 * p, 20);
         u_host.fin();
         chk_rd(a, (p == 3) ? 0 : 64, 10);
      end
      cmd(8'hFF, 0, 0);
      `CHK("keep", 6'h1F, {four_wire_command_mode, write_enable_latch, suspend_flag, wrap_config_bits})
      u_host.sel();
      u_host.shift(32'h7, 5, 1'b1);
      u_host.fin();
      `CHK("mode", 1'b0, four_wire_command_mode)
      cmd(8'h66, 0, 0);
      cmd(8'h7A, 0, 0);
      cmd(8'h99, 0, 0);
      `CHK("wel", 1'b1, write_enable_latch)
      // idle device, then the reset pair
      wait_idle();
      cmd(8'h66, 0, 0);
      cmd(8'h99, 0, 0);
      `CHK("busy", 1'b1, busy_flag)
      cmd(8'h38, 0, 0);
      `CHK("clean", 15'h0100, {four_wire_command_mode, write_enable_latch, suspend_flag, continuous_read_mode,
         wrap_config_bits, read_params})
      wait_idle();
      wrd(a, 8'h00, 0, 6);
      chk_rd(a, 0, 6);
      cmd(8'h38, 0, 0);
      `CHK("mode", 1'b1, four_wire_command_mode)
      end_sim();
   end
endmodule : sfmwr_ctrl_tb
`default_nettype wire
